//--- tb/dramc_host_props.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// controller pin discipline
module dramc_host_props #(
   parameter int unsigned POWERUP_CYC     = 20,
   parameter int unsigned REFRESH_GAP_CYC = 200
) (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       reset_n,
   // pins
   input wire logic       init_done,
   input wire logic       ras_n,
   input wire logic       cas_n,
   input wire logic       we_n,
   input wire logic       oe_n,
   input wire logic [7:0] addr,
   input wire logic       dq_oe_n
);
   logic [15:0] gap_q, gap_d, up_q, up_d;
   logic [3:0]  ini_q, ini_d;
   logic        ras_q, ras_d;
   // counters saturate so a long idle cannot wrap them back into range
   always_comb begin
      ras_d = ras_n;
      gap_d = (gap_q == 16'hffff) ? gap_q : gap_q + 16'h0001;
      up_d  = (up_q == 16'hffff) ? up_q : up_q + 16'h0001;
      ini_d = ini_q;
      if (ras_q && !ras_n) begin
         ini_d = (ini_q == 4'hf) ? ini_q : ini_q + 4'h1;
         if (!cas_n) begin
            gap_d = 16'h0000;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ras_q <= 1'b1;
         gap_q <= 16'h0000;
         up_q  <= 16'h0000;
         ini_q <= 4'h0;
      end else begin
         ras_q <= ras_d;
         gap_q <= gap_d;
         up_q  <= up_d;
         ini_q <= ini_d;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // assertions
   AST_WE_IN_ROW: assert property (!we_n |-> !ras_n)
      else $error("write strobe low outside a row cycle");
   AST_DATA_AT_FALL: assert property ($fell(cas_n) && !we_n |-> !dq_oe_n)
      else $error("write data not driven at column fall");
   AST_GATE_HIGH_WRITE: assert property (!we_n |-> oe_n)
      else $error("output gate low during write");
   AST_GATE_BEFORE_WE: assert property ($fell(we_n) |-> $past(oe_n))
      else $error("output gate not high before write strobe");
   AST_REFRESH_GAP: assert property (init_done |-> gap_q <= REFRESH_GAP_CYC + 64)
      else $error("refresh spacing too long");
   AST_POWERUP_WAIT: assert property (up_q + 2 < POWERUP_CYC |-> ras_n)
      else $error("row strobe during power-up pause");
   AST_INIT_COUNT: assert property ($rose(init_done) |-> ini_q >= 4'h8)
      else $error("ready before eight row cycles");
   AST_COL_ADDR_HOLD: assert property ($fell(cas_n) && !ras_n |=> $stable(addr))
      else $error("address moved after column fall");
   AST_RESET_STROBES: assert property (disable iff (1'b0)
      $past(!reset_n) |-> ras_n && cas_n && we_n && dq_oe_n)
      else $error("strobes not idle in reset");
endmodule
bind dramc_host dramc_host_props #(
   .POWERUP_CYC    (POWERUP_CYC),
   .REFRESH_GAP_CYC(REFRESH_GAP_CYC)
) u_props (
   .core_clk (core_clk),
   .reset_n  (reset_n),
   .init_done(init_done),
   .ras_n    (ras_n),
   .cas_n    (cas_n),
   .we_n     (we_n),
   .oe_n     (oe_n),
   .addr     (addr),
   .dq_oe_n  (dq_oe_n)
);
`default_nettype wire

//--- tb/dramc_host_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dramc_host_tb_top;
   localparam int unsigned PWR = 20;
   localparam int unsigned GAP = 200;
   typedef struct packed {
      logic       wr;
      logic [7:0] row;
      logic [7:0] col;
      logic [3:0] data;
   } dramc_row_t;
   // ==========================================================
   // table: write rows store data, read rows expect it
   localparam dramc_row_t ROWS [10] = '{
      {1'b1, 8'h00, 8'h00, 4'ha}, {1'b1, 8'h00, 8'hff, 4'h5},
      {1'b1, 8'hff, 8'h00, 4'h3}, {1'b1, 8'hff, 8'hff, 4'hc},
      {1'b0, 8'h00, 8'h00, 4'ha}, {1'b0, 8'hff, 8'hff, 4'hc},
      {1'b0, 8'h00, 8'hff, 4'h5}, {1'b1, 8'h00, 8'h00, 4'h6},
      {1'b0, 8'h00, 8'h00, 4'h6}, {1'b0, 8'hff, 8'h00, 4'h3}};
   localparam dramc_row_t MID = {1'b1, 8'h10, 8'h10, 4'h9};
   logic       core_clk, reset_n, req_valid, req_write, req_ready;
   logic       rsp_valid, init_done, ras_n, cas_n, we_n, oe_n, dq_oe_n;
   logic [7:0] req_row, req_col, addr, rfsh_row;
   logic [3:0] req_wdata, rsp_rdata, dq_out, dq_in;
   int         rfsh_count, bad_count, check_count, base;
   dramc_host #(.POWERUP_CYC(PWR), .REFRESH_GAP_CYC(GAP)) dut (
      .core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
      .req_write(req_write), .req_row(req_row), .req_col(req_col),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .init_done(init_done), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
   dramc_mem_model mem (
      .core_clk(core_clk), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .dq_in(dq_in), .rfsh_row(rfsh_row), .rfsh_count(rfsh_count));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic fail(input string msg);
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // the request stands until ready is seen high before a rising edge
   task automatic issue(input dramc_row_t r);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_write = r.wr;
      req_row   = r.row;
      req_col   = r.col;
      req_wdata = r.data;
      while (req_ready !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      if (n >= 2000) fail("request never taken");
      @(negedge core_clk);
      n = 0;
      while (!r.wr && rsp_valid !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      check_count++;
      if (!r.wr && (rsp_valid !== 1'b1 || rsp_rdata !== r.data)) begin
         fail("read data");
      end
   endtask
   task automatic wait_init();
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 5000) begin
         @(negedge core_clk);
         n++;
      end
      if (init_done !== 1'b1) fail("init never done");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      bad_count = 0;
      check_count = 0;
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_row = 8'h00;
      req_col = 8'h00;
      req_wdata = 4'h0;
      repeat (16) @(negedge core_clk);
      check_count++;
      if (ras_n !== 1'b1 || cas_n !== 1'b1) fail("strobes in reset");
      reset_n = 1'b1;
      wait_init();
      check_count++;
      if (rfsh_count < 8) fail("init refresh count");
      foreach (ROWS[i]) issue(ROWS[i]);
      base = rfsh_count;
      repeat (4 * GAP) @(negedge core_clk);
      check_count++;
      if (rfsh_count - base < 3) fail("refresh rate");
      check_count++;
      if (rfsh_row !== 8'(rfsh_count)) fail("refresh row");
      issue(ROWS[9]);
      // reset lands just after a write is taken, before its row strobe falls
      issue(MID);
      reset_n = 1'b0;
      repeat (3) @(negedge core_clk);
      check_count++;
      if (ras_n !== 1'b1 || req_ready !== 1'b0) fail("mid reset");
      base = rfsh_count;
      reset_n = 1'b1;
      wait_init();
      check_count++;
      if (rfsh_count - base < 8) fail("re-init count");
      issue(ROWS[5]);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fail("watchdog expired");
      wrap_up();
   end
endmodule
`default_nettype wire

//--- tb/dramc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// behavioural 64k x 4 page mode memory, sampled on the clock
module dramc_mem_model (
   // clock
   input  wire logic       core_clk,
   // dram pins
   input  wire logic       ras_n,
   input  wire logic       cas_n,
   input  wire logic       we_n,
   input  wire logic       oe_n,
   input  wire logic [7:0] addr,
   input  wire logic [3:0] dq_out,
   input  wire logic       dq_oe_n,
   output logic      [3:0] dq_in,
   // observation
   output logic      [7:0] rfsh_row,
   output int              rfsh_count
);
   logic [3:0] mem [0:65535];
   logic [7:0] row_q, col_q;
   logic       ras_q  = 1'b1;
   logic       cas_q  = 1'b1;
   logic       open_q = 1'b0;
   logic [3:0] last_q = 4'h0;
   logic       drive;
   initial rfsh_row = 8'h00;
   initial rfsh_count = 0;
   assign drive = open_q && !ras_n && !cas_n && !oe_n && we_n;
   // undriven pins toggle so a stale sample never looks valid
   assign dq_in = drive ? mem[{row_q, col_q}] : ~last_q;
   always @(posedge core_clk) begin
      ras_q  <= ras_n;
      cas_q  <= cas_n;
      last_q <= dq_in;
      if (ras_q && !ras_n) begin
         if (!cas_n) begin
            rfsh_row   <= rfsh_row + 8'h01;
            rfsh_count <= rfsh_count + 1;
         end else begin
            row_q <= addr;
         end
      end
      if (cas_n || ras_n) begin
         open_q <= 1'b0;
      end else if (cas_q) begin
         col_q  <= addr;
         open_q <= 1'b1;
         if (!we_n) begin
            mem[{row_q, addr}] <= dq_oe_n ? ~last_q : dq_out;
         end
      end
   end
endmodule
`default_nettype wire

//--- verilog/dramc_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host controller for a 64k x 4 page mode dram
module dramc_host #(
   parameter int unsigned POWERUP_CYC     = dramc_pkg::POWERUP_CYC,
   parameter int unsigned REFRESH_GAP_CYC = dramc_pkg::REFRESH_GAP_CYC,
   parameter int unsigned AW              = dramc_pkg::ADDR_W,
   parameter int unsigned DW              = dramc_pkg::DATA_W
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          reset_n,
   // user request
   input  wire logic          req_valid,
   input  wire logic          req_write,
   input  wire logic [AW-1:0] req_row,
   input  wire logic [AW-1:0] req_col,
   input  wire logic [DW-1:0] req_wdata,
   output logic               req_ready,
   output logic               rsp_valid,
   output logic [DW-1:0]      rsp_rdata,
   output logic               init_done,
   // dram pins
   output logic               ras_n,
   output logic               cas_n,
   output logic               we_n,
   output logic               oe_n,
   output logic [AW-1:0]      addr,
   output logic [DW-1:0]      dq_out,
   output logic               dq_oe_n,
   input  wire logic [DW-1:0] dq_in
);
   localparam int unsigned TW = 24;

   dramc_pkg::dramc_state_t st_q;
   dramc_pkg::dramc_state_t st_d;
   logic [TW-1:0] wait_q, wait_d;
   logic [3:0]    ph_q, ph_d;
   logic [3:0]    init_q, init_d;
   logic          wr_q, wr_d;
   logic [AW-1:0] col_q, col_d;
   logic [DW-1:0] wd_q, wd_d;
   logic          ras_q, ras_d, cas_q, cas_d, we_q, we_d, oe_q, oe_d;
   logic [AW-1:0] addr_q, addr_d;
   logic          dqoe_q, dqoe_d;
   logic          rdy_q, rdy_d, rv_q, rv_d, done_q, done_d;
   logic [DW-1:0] rd_q, rd_d;
   logic          rf_due_q, rf_due_d;
   logic          tick;
   logic          rf_tick;

   // phase enable for strobe timing
   dramc_timer #(.PERIOD(dramc_pkg::TICK_DIV), .W(4)) u_tick (
      .clk     (core_clk),
      .reset_n (reset_n),
      .restart (1'b0),
      .tick    (tick)
   );

   // refresh pacing; only a counter refresh cycle clears the due flag for that slot
   dramc_timer #(.PERIOD(REFRESH_GAP_CYC), .W(TW)) u_rf (
      .clk     (core_clk),
      .reset_n (reset_n),
      .restart (1'b0),
      .tick    (rf_tick)
   );

   function automatic logic ph_end(input logic [3:0] ph,
                                   input logic [3:0] lim);
      ph_end = (ph == lim);
   endfunction

   always_comb begin
      st_d     = st_q;
      wait_d   = wait_q;
      ph_d     = tick ? ph_q + 4'h1 : ph_q;
      init_d   = init_q;
      wr_d     = wr_q;
      col_d    = col_q;
      wd_d     = wd_q;
      ras_d    = ras_q;
      cas_d    = cas_q;
      we_d     = we_q;
      oe_d     = oe_q;
      addr_d   = addr_q;
      dqoe_d   = dqoe_q;
      rdy_d    = 1'b0;
      rv_d     = 1'b0;
      rd_d     = rd_q;
      done_d   = done_q;
      rf_due_d = rf_due_q | rf_tick;
      unique case (st_q)
         dramc_pkg::DRAMC_POWERUP: begin
            // strobes stay high through the pause
            wait_d = wait_q + 1'b1;
            if (wait_q == TW'(POWERUP_CYC - 1)) begin
               init_d = 4'h0;
               st_d   = dramc_pkg::DRAMC_IDLE;
            end
         end
         dramc_pkg::DRAMC_IDLE: begin
            ph_d = 4'h0;
            if (!done_q || rf_due_q) begin
               // init cycles and refresh both use counter refresh
               cas_d = 1'b0;
               st_d  = dramc_pkg::DRAMC_CBR_CAS;
               if (rf_due_q && !rf_tick) begin
                  rf_due_d = 1'b0;
               end
            end else if (req_valid && rdy_q) begin
               wr_d   = req_write;
               col_d  = req_col;
               wd_d   = req_wdata;
               addr_d = req_row;
               oe_d   = 1'b1;
               st_d   = dramc_pkg::DRAMC_ROW;
            end else begin
               // ready only when the next idle cycle is sure to take it
               rdy_d = !rf_tick;
            end
         end
         dramc_pkg::DRAMC_ROW: begin
            if (tick && ph_end(ph_q, dramc_pkg::PH_ROW_SETUP)) begin
               ras_d = 1'b0;
            end else if (tick && ph_end(ph_q, dramc_pkg::PH_ROW_HOLD)) begin
               addr_d = col_q;
               ph_d   = 4'h0;
               if (wr_q) begin
                  // gate already high, data out once gate delay passes
                  st_d = dramc_pkg::DRAMC_GATE;
               end else begin
                  cas_d = 1'b0;
                  oe_d  = 1'b0;
                  st_d  = dramc_pkg::DRAMC_COL;
               end
            end
         end
         dramc_pkg::DRAMC_GATE: begin
            if (tick && ph_end(ph_q, dramc_pkg::PH_GATE_DATA)) begin
               dqoe_d = 1'b0;
               we_d   = 1'b0;
               ph_d   = 4'h0;
               st_d   = dramc_pkg::DRAMC_WRITE;
            end
         end
         dramc_pkg::DRAMC_WRITE: begin
            // write strobe fell first: early write, column fall latches
            if (tick && ph_end(ph_q, dramc_pkg::PH_ROW_SETUP)) begin
               cas_d = 1'b0;
               ph_d  = 4'h0;
               st_d  = dramc_pkg::DRAMC_COL;
            end
         end
         dramc_pkg::DRAMC_COL: begin
            if (tick && ph_end(ph_q, dramc_pkg::PH_COL_LOW)) begin
               if (!wr_q) begin
                  rd_d = dq_in;
                  rv_d = 1'b1;
               end
               cas_d  = 1'b1;
               ph_d   = 4'h0;
               st_d   = dramc_pkg::DRAMC_COL_PRE;
            end
         end
         dramc_pkg::DRAMC_COL_PRE: begin
            we_d   = 1'b1;
            dqoe_d = 1'b1;
            oe_d   = 1'b1;
            // each access closes its row; page bursts are not offered
            if (tick && ph_end(ph_q, dramc_pkg::PH_COL_PRE)) begin
               ph_d  = 4'h0;
               ras_d = 1'b1;
               st_d  = dramc_pkg::DRAMC_PRE;
            end
         end
         dramc_pkg::DRAMC_CBR_CAS: begin
            if (tick && ph_end(ph_q, dramc_pkg::PH_ROW_SETUP)) begin
               ras_d = 1'b0;
            end else if (tick && ph_end(ph_q, dramc_pkg::PH_ROW_HOLD)) begin
               ph_d = 4'h0;
               st_d = dramc_pkg::DRAMC_CBR_RAS;
            end
         end
         dramc_pkg::DRAMC_CBR_RAS: begin
            if (tick && ph_end(ph_q, dramc_pkg::PH_COL_LOW)) begin
               ras_d = 1'b1;
               cas_d = 1'b1;
               ph_d  = 4'h0;
               if (!done_q) begin
                  init_d = init_q + 4'h1;
                  if (init_q == 4'(dramc_pkg::INIT_CYCLES - 1)) begin
                     done_d = 1'b1;
                  end
               end
               st_d = dramc_pkg::DRAMC_PRE;
            end
         end
         dramc_pkg::DRAMC_PRE: begin
            if (tick && ph_end(ph_q, dramc_pkg::PH_PRECHARGE)) begin
               ph_d = 4'h0;
               st_d = dramc_pkg::DRAMC_IDLE;
            end
         end
         default: begin
            st_d = dramc_pkg::DRAMC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_q     <= dramc_pkg::DRAMC_POWERUP;
         wait_q   <= '0;
         ph_q     <= 4'h0;
         init_q   <= 4'h0;
         wr_q     <= 1'b0;
         col_q    <= '0;
         wd_q     <= '0;
         ras_q    <= 1'b1;
         cas_q    <= 1'b1;
         we_q     <= 1'b1;
         oe_q     <= 1'b1;
         addr_q   <= '0;
         dqoe_q   <= 1'b1;
         rdy_q    <= 1'b0;
         rv_q     <= 1'b0;
         rd_q     <= '0;
         done_q   <= 1'b0;
         rf_due_q <= 1'b0;
      end else begin
         st_q     <= st_d;
         wait_q   <= wait_d;
         ph_q     <= ph_d;
         init_q   <= init_d;
         wr_q     <= wr_d;
         col_q    <= col_d;
         wd_q     <= wd_d;
         ras_q    <= ras_d;
         cas_q    <= cas_d;
         we_q     <= we_d;
         oe_q     <= oe_d;
         addr_q   <= addr_d;
         dqoe_q   <= dqoe_d;
         rdy_q    <= rdy_d;
         rv_q     <= rv_d;
         rd_q     <= rd_d;
         done_q   <= done_d;
         rf_due_q <= rf_due_d;
      end
   end

   assign req_ready = rdy_q;
   assign rsp_valid = rv_q;
   assign rsp_rdata = rd_q;
   assign init_done = done_q;
   assign ras_n     = ras_q;
   assign cas_n     = cas_q;
   assign we_n      = we_q;
   assign oe_n      = oe_q;
   assign addr      = addr_q;
   assign dq_out    = wd_q;
   assign dq_oe_n   = dqoe_q;
endmodule
`default_nettype wire

//--- verilog/dramc_pkg.sv
// Behaviour
// - write: controller drives write and column strobes low while row strobe low.
// - write data valid at or before the later of write or column fall.
// - late write: controller holds output gate high, waits gate-to-data delay.
// - controller issues 256 refresh cycles within every 4 ms window.
// - row strobe held low keeps row latched for page column accesses.
// - controller raises output gate before write strobe falls.
// - after power-up wait 200 us then issue at least 8 row cycles.
// - after idle beyond refresh interval, reissue eight init row cycles; the controller does not, init_done stays set until reset.
// - keep row and column strobes high during power-up.
package dramc_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_MHZ          = 50;
   localparam int unsigned POWERUP_US       = 200;
   localparam int unsigned POWERUP_CYC      = POWERUP_US * CLK_MHZ;
   localparam int unsigned REFRESH_MS       = 4;
   localparam int unsigned REFRESH_ROWS     = 256;
   localparam int unsigned REFRESH_WIN_CYC  = REFRESH_MS * 1000 * CLK_MHZ;
   // spacing leaves margin: 256 refreshes well inside the window
   localparam int unsigned REFRESH_GAP_CYC  = REFRESH_WIN_CYC / REFRESH_ROWS
                                              - 16;
   localparam int unsigned INIT_CYCLES      = 8;
   // ==========================================================
   // strobe phase lengths, in ticks of the phase enable
   localparam int unsigned TICK_DIV         = 2;
   localparam logic [3:0]  PH_ROW_SETUP     = 4'h1;
   localparam logic [3:0]  PH_ROW_HOLD      = 4'h2;
   localparam logic [3:0]  PH_COL_LOW       = 4'h3;
   localparam logic [3:0]  PH_GATE_DATA     = 4'h1;
   localparam logic [3:0]  PH_PRECHARGE     = 4'h3;
   localparam logic [3:0]  PH_COL_PRE       = 4'h1;
   // ==========================================================
   // widths
   localparam int unsigned ADDR_W           = 8;
   localparam int unsigned DATA_W           = 4;
   // ==========================================================
   // controller states
   typedef enum logic [3:0] {
      DRAMC_POWERUP   = 4'h0,
      DRAMC_IDLE      = 4'h1,
      DRAMC_ROW       = 4'h2,
      DRAMC_COL       = 4'h3,
      DRAMC_GATE      = 4'h4,
      DRAMC_WRITE     = 4'h5,
      DRAMC_COL_PRE   = 4'h6,
      DRAMC_PRE       = 4'h7,
      DRAMC_CBR_CAS   = 4'h8,
      DRAMC_CBR_RAS   = 4'h9
   } dramc_state_t;
endpackage

//--- verilog/dramc_timer.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// free counter raising a one-cycle pulse every period cycles
module dramc_timer #(
   parameter int unsigned PERIOD = 2,
   parameter int unsigned W      = 24
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // control
   input  wire logic restart,
   output logic      tick
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         tick_q;
   logic         tick_d;

   always_comb begin
      cnt_d  = cnt_q + 1'b1;
      tick_d = 1'b0;
      if (restart) begin
         cnt_d = '0;
      end else if (cnt_q == W'(PERIOD - 1)) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule
`default_nettype wire
